/* File: timer_channel_pkg.sv */
// ============================================================
// register map and field layout of one timer channel
// ============================================================
package timer_channel_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_CONTROL = 8'h00; // write-only command word
  localparam logic [7:0] OFS_MODE = 8'h04; // mode and line effects
  localparam logic [7:0] OFS_COUNT = 8'h10; // counter_value_reg
  localparam logic [7:0] OFS_CMP_A = 8'h14; // compare_a_reg
  localparam logic [7:0] OFS_CMP_B = 8'h18; // compare_b_reg
  localparam logic [7:0] OFS_CMP_C = 8'h1c; // compare_c_reg
  localparam logic [7:0] OFS_STATUS = 8'h20; // channel_status_reg
  localparam logic [7:0] OFS_IRQ_SET = 8'h24; // irq_enable_set_reg
  localparam logic [7:0] OFS_IRQ_CLR = 8'h28; // irq_enable_clear_reg
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2c; // read-only enable mask

  // command word bits
  localparam int CTL_CLK_ON = 0; // start counter clock
  localparam int CTL_CLK_OFF = 1; // stop counter clock
  localparam int CTL_SW_TRIG = 2; // software trigger

  // mode word bits and fields (low bit of each 2-bit effect field)
  localparam int MODE_LIMIT_TRIG = 14; // compare_c_limit match restarts count
  localparam int MODE_PATTERN = 15; // pattern_mode_flag
  localparam int FLD_A_MATCH_A = 16; // a_match_effect_line_a
  localparam int FLD_C_MATCH_A = 18; // c_match_effect_line_a
  localparam int FLD_EXT_A = 20; // ext_event_effect_line_a
  localparam int FLD_SW_A = 22; // sw_trigger_effect_line_a
  localparam int FLD_B_MATCH_B = 24; // b_match_effect_line_b
  localparam int FLD_C_MATCH_B = 26; // c_match_effect_line_b
  localparam int FLD_EXT_B = 28; // ext_event_effect_line_b
  localparam int FLD_SW_B = 30; // sw_trigger_effect_line_b

  // status flag positions
  localparam int ST_OVERFLOW = 0; // overflow_flag
  localparam int ST_OVERRUN = 1; // load_overrun_flag
  localparam int ST_MATCH_A = 2; // match_a_flag
  localparam int ST_MATCH_B = 3; // match_b_flag
  localparam int ST_MATCH_C = 4; // match_c_flag
  localparam int ST_LOAD_A = 5; // load_a_flag
  localparam int ST_LOAD_B = 6; // load_b_flag
  localparam int ST_EXT_TRIG = 7; // ext_trigger_flag
  localparam int ST_CLK_ON = 16; // counter_clock_on
  localparam int ST_MIRROR_A = 17; // line_a_mirror
  localparam int ST_MIRROR_B = 18; // line_b_mirror

  // flags visible in each mode
  localparam logic [7:0] FLAGS_PATTERN = 8'h9d;
  localparam logic [7:0] FLAGS_CAPTURE = 8'hf3;

  // line effect encodings
  localparam logic [1:0] EFF_NONE = 2'h0;
  localparam logic [1:0] EFF_SET = 2'h1;
  localparam logic [1:0] EFF_CLEAR = 2'h2;
  localparam logic [1:0] EFF_TOGGLE = 2'h3;

  // reset values
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

endpackage

/* File: timer_channel.sv */
// What this block does
// - limit match drives line a per field
// - external event drives line a per field
// - software trigger drives line a per field
// - compare b match drives line b
// - limit match drives line b per field
// - external event drives line b per field
// - software trigger drives line b per field
// - live counter readable, upper bits zero
// - compare a writable only in pattern mode
// - compare b writable only in pattern mode
// - compare c limit always read/write
// - overflow flag sticky, cleared by status read
// - load overrun flag, capture mode only
// - compare a/b match flags, pattern mode only
// - limit match flag in both modes
// - capture load flags, capture mode only
// - external trigger flag sticky until read
// - status shows counter clock enabled
// - status mirrors both timer lines
// - writing ones sets interrupt enables
// - writing ones clears interrupt enables
// - enables readable as mask word
// - pattern flag selects waveform or capture
`timescale 1ns/1ps
module timer_channel #(
  parameter int CNT_W = 16 // counter and compare width
) (
  input wire logic core_clk_i, // peripheral clock
  input wire logic rst_i, // synchronous reset, active high
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // counting and events
  input wire logic count_tick_i, // one pulse per selected counter clock edge
  input wire logic ext_event_i, // one pulse per selected external event
  // timer lines as two-way pins
  input wire logic timer_line_a_i,
  output logic timer_line_a_o,
  output logic timer_line_a_oe_o,
  input wire logic timer_line_b_i,
  output logic timer_line_b_o,
  output logic timer_line_b_oe_o,
  output logic irq_o // channel interrupt
);

  // ==========================================================
  // state
  // ==========================================================
  logic [CNT_W-1:0] count_ff, nxt_count; // count_now
  logic [CNT_W-1:0] cmp_a_ff, nxt_cmp_a; // capture_compare_a
  logic [CNT_W-1:0] cmp_b_ff, nxt_cmp_b; // capture_compare_b
  logic [CNT_W-1:0] cmp_c_ff, nxt_cmp_c; // compare_c_limit
  logic [31:0] mode_ff, nxt_mode; // mode word
  logic clk_on_ff, nxt_clk_on; // counter_clock_on
  logic [7:0] flags_ff, nxt_flags; // sticky status flags
  logic [7:0] irq_en_ff, nxt_irq_en; // interrupt enables
  logic line_a_ff, nxt_line_a; // driven level of line a
  logic line_b_ff, nxt_line_b; // driven level of line b
  logic pin_a_prev_ff, nxt_pin_a_prev; // last sampled line a pin
  logic unread_a_ff, nxt_unread_a; // compare a loaded, not yet read
  logic unread_b_ff, nxt_unread_b; // compare b loaded, not yet read
  logic wr_pend_ff, nxt_wr_pend; // write data phase pending
  logic [7:0] wr_addr_ff, nxt_wr_addr; // address of pending write
  logic [31:0] rdata_ff, nxt_rdata; // read data for data phase

  // ==========================================================
  // decode and events
  // ==========================================================
  logic pattern; // waveform mode selected
  logic acc, rd_acc; // accepted transfer, accepted read
  logic st_rd, a_rd, b_rd; // reads with side effects
  logic ctl_wr; // command word written
  logic sw_trig; // software trigger command
  logic step; // counter advances this cycle
  logic hit_a, hit_b, hit_c, wrap; // compare matches and overflow
  logic load_a, load_b; // capture loads
  logic overrun; // load while previous unread
  logic [7:0] ev; // flag set events
  logic [7:0] vis; // flags visible in current mode
  logic [31:0] status; // status word as read

  assign pattern = mode_ff[timer_channel_pkg::MODE_PATTERN];
  assign acc = hsel_i && hready_i && htrans_i[1];
  assign rd_acc = acc && !hwrite_i;
  assign st_rd = rd_acc && (haddr_i == timer_channel_pkg::OFS_STATUS);
  assign a_rd = rd_acc && (haddr_i == timer_channel_pkg::OFS_CMP_A);
  assign b_rd = rd_acc && (haddr_i == timer_channel_pkg::OFS_CMP_B);
  assign ctl_wr = wr_pend_ff && (wr_addr_ff == timer_channel_pkg::OFS_CONTROL);
  assign sw_trig = ctl_wr && hwdata_i[timer_channel_pkg::CTL_SW_TRIG];
  assign step = clk_on_ff && count_tick_i;
  assign hit_a = step && (count_ff == cmp_a_ff);
  assign hit_b = step && (count_ff == cmp_b_ff);
  assign hit_c = step && (count_ff == cmp_c_ff);
  assign wrap = step && (count_ff == {CNT_W{1'b1}});
  // capture edges of line a: rising loads a, falling loads b
  assign load_a = !pattern && clk_on_ff && timer_line_a_i && !pin_a_prev_ff;
  assign load_b = !pattern && clk_on_ff && !timer_line_a_i && pin_a_prev_ff;
  assign overrun = (load_a && unread_a_ff) || (load_b && unread_b_ff);

  assign ev[timer_channel_pkg::ST_OVERFLOW] = wrap;
  assign ev[timer_channel_pkg::ST_OVERRUN] = !pattern && overrun;
  // compare a/b matches only in pattern mode, limit match in both
  assign ev[timer_channel_pkg::ST_MATCH_A] = pattern && hit_a;
  assign ev[timer_channel_pkg::ST_MATCH_B] = pattern && hit_b;
  assign ev[timer_channel_pkg::ST_MATCH_C] = hit_c;
  // capture loads only in capture mode
  assign ev[timer_channel_pkg::ST_LOAD_A] = load_a;
  assign ev[timer_channel_pkg::ST_LOAD_B] = load_b;
  assign ev[timer_channel_pkg::ST_EXT_TRIG] = ext_event_i;

  assign vis = pattern ? timer_channel_pkg::FLAGS_PATTERN
                       : timer_channel_pkg::FLAGS_CAPTURE;

  // status word; mode-hidden flags read as zero
  always_comb begin
    status = 32'h0;
    status[7:0] = flags_ff & vis;
    status[timer_channel_pkg::ST_CLK_ON] = clk_on_ff;
    status[timer_channel_pkg::ST_MIRROR_A] = pattern ? line_a_ff : timer_line_a_i;
    status[timer_channel_pkg::ST_MIRROR_B] = pattern ? line_b_ff : timer_line_b_i;
  end

  // applies one 2-bit effect to a line level
  function automatic logic apply_eff(input logic cur, input logic [1:0] eff);
    logic res;
    res = cur;
    case (eff)
      timer_channel_pkg::EFF_SET: res = 1'b1;
      timer_channel_pkg::EFF_CLEAR: res = 1'b0;
      timer_channel_pkg::EFF_TOGGLE: res = !cur;
      default: res = cur;
    endcase
    return res;
  endfunction

  // picks the 2-bit field at a low-bit position of the mode word
  function automatic logic [1:0] fld(input logic [31:0] m, input int pos);
    return m[pos +: 2];
  endfunction

  // ==========================================================
  // bus slave: zero wait, always okay
  // ==========================================================
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_ff;

  // read data is fetched in the address phase and held in the data phase
  always_comb begin
    nxt_wr_pend = acc && hwrite_i;
    nxt_wr_addr = acc ? haddr_i : wr_addr_ff;
    nxt_rdata = rdata_ff;
    if (rd_acc) begin
      unique case (haddr_i)
        timer_channel_pkg::OFS_MODE: nxt_rdata = mode_ff;
        timer_channel_pkg::OFS_COUNT: nxt_rdata = 32'(count_ff);
        timer_channel_pkg::OFS_CMP_A: nxt_rdata = 32'(cmp_a_ff);
        timer_channel_pkg::OFS_CMP_B: nxt_rdata = 32'(cmp_b_ff);
        timer_channel_pkg::OFS_CMP_C: nxt_rdata = 32'(cmp_c_ff);
        timer_channel_pkg::OFS_STATUS: nxt_rdata = status;
        timer_channel_pkg::OFS_IRQ_MASK: nxt_rdata = 32'(irq_en_ff);
        default: nxt_rdata = 32'h0; // unmapped and write-only read zero
      endcase
    end
  end

  // ==========================================================
  // registers, counter, flags and lines
  // ==========================================================
  always_comb begin
    nxt_mode = mode_ff;
    nxt_cmp_a = cmp_a_ff;
    nxt_cmp_b = cmp_b_ff;
    nxt_cmp_c = cmp_c_ff;
    nxt_irq_en = irq_en_ff;
    nxt_clk_on = clk_on_ff;
    nxt_count = count_ff;
    nxt_line_a = line_a_ff;
    nxt_line_b = line_b_ff;
    nxt_pin_a_prev = timer_line_a_i;
    // software writes in the data phase
    if (wr_pend_ff) begin
      unique case (wr_addr_ff)
        timer_channel_pkg::OFS_MODE: nxt_mode = hwdata_i;
        // compare a only in pattern mode
        timer_channel_pkg::OFS_CMP_A: if (pattern) nxt_cmp_a = hwdata_i[CNT_W-1:0];
        // compare b only in pattern mode
        timer_channel_pkg::OFS_CMP_B: if (pattern) nxt_cmp_b = hwdata_i[CNT_W-1:0];
        timer_channel_pkg::OFS_CMP_C: nxt_cmp_c = hwdata_i[CNT_W-1:0];
        timer_channel_pkg::OFS_IRQ_SET: nxt_irq_en = irq_en_ff | hwdata_i[7:0];
        timer_channel_pkg::OFS_IRQ_CLR: nxt_irq_en = irq_en_ff & ~hwdata_i[7:0];
        default: nxt_irq_en = irq_en_ff; // others have no stored effect
      endcase
    end
    // counter clock commands; disable wins over enable
    if (ctl_wr && hwdata_i[timer_channel_pkg::CTL_CLK_ON]) nxt_clk_on = 1'b1;
    if (ctl_wr && hwdata_i[timer_channel_pkg::CTL_CLK_OFF]) nxt_clk_on = 1'b0;
    // counting, with restart on trigger or limit
    if (step) nxt_count = count_ff + 1'b1;
    if (hit_c && mode_ff[timer_channel_pkg::MODE_LIMIT_TRIG]) begin
      nxt_count = '0;
    end
    if (sw_trig && !(ctl_wr && hwdata_i[timer_channel_pkg::CTL_CLK_OFF])) begin
      nxt_count = '0;
      nxt_clk_on = 1'b1;
    end
    // capture loads take the counter value
    if (load_a) nxt_cmp_a = count_ff;
    if (load_b) nxt_cmp_b = count_ff;
    // line effects; one source per line per cycle, trigger over event over limit match over a/b matches
    if (pattern) begin
      if (sw_trig) begin
        nxt_line_a = apply_eff(line_a_ff, fld(mode_ff, timer_channel_pkg::FLD_SW_A));
        nxt_line_b = apply_eff(line_b_ff, fld(mode_ff, timer_channel_pkg::FLD_SW_B));
      end else if (ext_event_i) begin
        nxt_line_a = apply_eff(line_a_ff, fld(mode_ff, timer_channel_pkg::FLD_EXT_A));
        nxt_line_b = apply_eff(line_b_ff, fld(mode_ff, timer_channel_pkg::FLD_EXT_B));
      end else begin
        if (hit_c) begin
          nxt_line_a = apply_eff(line_a_ff, fld(mode_ff, timer_channel_pkg::FLD_C_MATCH_A));
          nxt_line_b = apply_eff(line_b_ff, fld(mode_ff, timer_channel_pkg::FLD_C_MATCH_B));
        end else begin
          if (hit_a) begin
            nxt_line_a = apply_eff(line_a_ff, fld(mode_ff, timer_channel_pkg::FLD_A_MATCH_A));
          end
          if (hit_b) begin
            // compare b match on line b
            nxt_line_b = apply_eff(line_b_ff, fld(mode_ff, timer_channel_pkg::FLD_B_MATCH_B));
          end
        end
      end
    end
  end

  // sticky flags: a new event wins over a status read in the same cycle
  always_comb begin
    nxt_flags = (st_rd ? timer_channel_pkg::FLAGS_RESET : flags_ff) | ev;
    // unread trackers: a new load wins over the read
    nxt_unread_a = load_a || (unread_a_ff && !a_rd && !st_rd);
    nxt_unread_b = load_b || (unread_b_ff && !b_rd && !st_rd);
  end

  // registering of all state
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      count_ff <= '0;
      cmp_a_ff <= '0;
      cmp_b_ff <= '0;
      cmp_c_ff <= '0;
      mode_ff <= timer_channel_pkg::MODE_RESET;
      clk_on_ff <= 1'b0;
      flags_ff <= timer_channel_pkg::FLAGS_RESET;
      irq_en_ff <= 8'h00;
      line_a_ff <= 1'b0;
      line_b_ff <= 1'b0;
      pin_a_prev_ff <= 1'b0;
      unread_a_ff <= 1'b0;
      unread_b_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff <= 32'h0;
    end else begin
      count_ff <= nxt_count;
      cmp_a_ff <= nxt_cmp_a;
      cmp_b_ff <= nxt_cmp_b;
      cmp_c_ff <= nxt_cmp_c;
      mode_ff <= nxt_mode;
      clk_on_ff <= nxt_clk_on;
      flags_ff <= nxt_flags;
      irq_en_ff <= nxt_irq_en;
      line_a_ff <= nxt_line_a;
      line_b_ff <= nxt_line_b;
      pin_a_prev_ff <= nxt_pin_a_prev;
      unread_a_ff <= nxt_unread_a;
      unread_b_ff <= nxt_unread_b;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  // lines are driven only in pattern mode
  assign timer_line_a_o = line_a_ff;
  assign timer_line_b_o = line_b_ff;
  assign timer_line_a_oe_o = pattern;
  assign timer_line_b_oe_o = pattern;
  // enabled visible flags raise the interrupt
  assign irq_o = |(flags_ff & vis & irq_en_ff);

  // ==========================================================
  // checks
  // ==========================================================
  property p_lim_set_a;
    @(posedge core_clk_i) disable iff (rst_i)
      (pattern && hit_c && !sw_trig && !ext_event_i
       && fld(mode_ff, timer_channel_pkg::FLD_C_MATCH_A) == timer_channel_pkg::EFF_SET)
      |=> timer_line_a_o;
  endproperty
  a_lim_set_a: assert property (p_lim_set_a) else $error("limit set on line a missed");

  property p_sw_tog_b;
    @(posedge core_clk_i) disable iff (rst_i)
      (pattern && sw_trig
       && fld(mode_ff, timer_channel_pkg::FLD_SW_B) == timer_channel_pkg::EFF_TOGGLE)
      |=> timer_line_b_o != $past(timer_line_b_o);
  endproperty
  a_sw_tog_b: assert property (p_sw_tog_b) else $error("trigger toggle on line b missed");

  property p_ext_clr_a;
    @(posedge core_clk_i) disable iff (rst_i)
      (pattern && ext_event_i && !sw_trig
       && fld(mode_ff, timer_channel_pkg::FLD_EXT_A) == timer_channel_pkg::EFF_CLEAR)
      |=> !timer_line_a_o;
  endproperty
  a_ext_clr_a: assert property (p_ext_clr_a) else $error("event clear on line a missed");

  property p_ovf_sticky;
    @(posedge core_clk_i) disable iff (rst_i)
      (wrap || (flags_ff[timer_channel_pkg::ST_OVERFLOW] && !st_rd))
      |=> flags_ff[timer_channel_pkg::ST_OVERFLOW];
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

  property p_rd_clears;
    @(posedge core_clk_i) disable iff (rst_i)
      (st_rd && ev == 8'h00) |=> flags_ff == 8'h00;
  endproperty
  a_rd_clears: assert property (p_rd_clears) else $error("status read did not clear");

  property p_cmp_a_locked;
    @(posedge core_clk_i) disable iff (rst_i)
      (!pattern && !load_a) |=> cmp_a_ff == $past(cmp_a_ff);
  endproperty
  a_cmp_a_locked: assert property (p_cmp_a_locked) else $error("compare a changed");

  property p_ier_sets;
    @(posedge core_clk_i) disable iff (rst_i)
      (wr_pend_ff && wr_addr_ff == timer_channel_pkg::OFS_IRQ_SET)
      |=> (irq_en_ff & $past(hwdata_i[7:0])) == $past(hwdata_i[7:0]);
  endproperty
  a_ier_sets: assert property (p_ier_sets) else $error("enable not set");

  property p_idr_clears;
    @(posedge core_clk_i) disable iff (rst_i)
      (wr_pend_ff && wr_addr_ff == timer_channel_pkg::OFS_IRQ_CLR)
      |=> (irq_en_ff & $past(hwdata_i[7:0])) == 8'h00;
  endproperty
  a_idr_clears: assert property (p_idr_clears) else $error("enable not cleared");

  property p_mode_hide;
    @(posedge core_clk_i) disable iff (rst_i)
      pattern |-> status[timer_channel_pkg::ST_LOAD_A] == 1'b0
                  && status[timer_channel_pkg::ST_OVERRUN] == 1'b0;
  endproperty
  a_mode_hide: assert property (p_mode_hide) else $error("capture flag seen in pattern mode");

  property p_irq;
    @(posedge core_clk_i) disable iff (rst_i)
      (ev[timer_channel_pkg::ST_MATCH_C] && irq_en_ff[timer_channel_pkg::ST_MATCH_C]
       && !(wr_pend_ff && wr_addr_ff == timer_channel_pkg::OFS_IRQ_CLR)) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule // timer_channel

/* File: test_timer_channel_outputs_status.sv */
`timescale 1ns/1ps
module test_timer_channel_outputs_status;
  // ==========================================================
  // bench signals
  logic core_clk_i, rst_i, hsel, hwrite, tick, ext, pa, pb;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, rdat;
  logic [31:0] hrdata;
  logic hready, hresp, la, la_oe, lb, lb_oe, irq;
  logic ea, eb; // expected line levels
  int err_total, cmp_count, cyc;
  localparam logic [31:0] PAT = 32'h1 << timer_channel_pkg::MODE_PATTERN;

  // ==========================================================
  // design under test
  timer_channel DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .count_tick_i(tick),
    .ext_event_i(ext), .timer_line_a_i(pa), .timer_line_a_o(la), .timer_line_a_oe_o(la_oe),
    .timer_line_b_i(pb), .timer_line_b_o(lb), .timer_line_b_oe_o(lb_oe), .irq_o(irq));

  // clock, 5 ns period
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // hang guard
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      $display("mismatch at %0t: timeout", $time);
      results();
    end
  end

  // ==========================================================
  // helpers
  task automatic results();
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one ahb-lite single transfer; read data taken at the data-phase edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk_i); while (hready !== 1'b1);
    rdat = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  // counter ticks, one per edge
  task automatic tick_n(input int n);
    tick <= 1'b1;
    repeat (n) @(posedge core_clk_i);
    tick <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask

  task automatic ext_pulse();
    ext <= 1'b1;
    @(posedge core_clk_i);
    ext <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask

  // software trigger: count cleared, clock started
  task automatic trig();
    wr(timer_channel_pkg::OFS_CONTROL, 32'h4);
    repeat (2) @(posedge core_clk_i);
  endtask

  function automatic logic eff(input logic l, input int c);
    return (c == 0) ? l : (c == 1) ? 1'b1 : (c == 2) ? 1'b0 : ~l;
  endfunction

  // ==========================================================
  // scenarios
  task automatic regs();
    logic [31:0] old;
    wr(timer_channel_pkg::OFS_MODE, 32'h0);
    rd(timer_channel_pkg::OFS_CMP_A);
    old = rdat;
    wr(timer_channel_pkg::OFS_CMP_A, 32'h1234);
    rd(timer_channel_pkg::OFS_CMP_A);
    chk(rdat, old, "cmp a capture write");
    rd(timer_channel_pkg::OFS_CMP_B);
    old = rdat;
    wr(timer_channel_pkg::OFS_CMP_B, 32'h4321);
    rd(timer_channel_pkg::OFS_CMP_B);
    chk(rdat, old, "cmp b capture write");
    wr(timer_channel_pkg::OFS_CMP_C, 32'hffff_a5a5);
    rd(timer_channel_pkg::OFS_CMP_C);
    chk(rdat, 32'h0000_a5a5, "cmp c");
    chk({la_oe, lb_oe}, 32'h0, "oe capture");
    wr(timer_channel_pkg::OFS_MODE, PAT);
    wr(timer_channel_pkg::OFS_CMP_A, 32'h1234);
    wr(timer_channel_pkg::OFS_CMP_B, 32'hbeef);
    rd(timer_channel_pkg::OFS_CMP_A);
    chk(rdat, 32'h1234, "cmp a pattern");
    rd(timer_channel_pkg::OFS_CMP_B);
    chk(rdat, 32'hbeef, "cmp b pattern");
    rd(8'h3c);
    chk(rdat, 32'h0, "unmapped");
    wr(timer_channel_pkg::OFS_CMP_A, 32'h0);
    wr(timer_channel_pkg::OFS_CMP_B, 32'h0);
    wr(timer_channel_pkg::OFS_CMP_C, 32'h0);
  endtask

  // every effect code on both lines; src 0 sw, 1 ext, 2 match at count 0
  task automatic effects(input int fa, input int fb, input int src);
    for (int c = 0; c < 4; c++) begin
      wr(timer_channel_pkg::OFS_MODE, PAT | (32'(c) << fa) | (32'(3 - c) << fb));
      if (src == 1) begin
        ext_pulse();
      end else begin
        trig();
        if (src == 2) begin
          tick_n(1);
        end
      end
      ea = eff(ea, c);
      eb = eff(eb, 3 - c);
      chk({la_oe, lb_oe, la, lb}, {28'h0, 2'h3, ea, eb}, "lines");
      rd(timer_channel_pkg::OFS_STATUS);
      chk(rdat[18:17], {eb, ea}, "mirror");
    end
  endtask

  task automatic flags();
    wr(timer_channel_pkg::OFS_CMP_C, 32'h0);
    wr(timer_channel_pkg::OFS_MODE, PAT);
    rd(timer_channel_pkg::OFS_STATUS);
    trig();
    tick_n(1);
    ext_pulse();
    rd(timer_channel_pkg::OFS_STATUS);
    chk(rdat[16:0], 32'h1009c, "flags set");
    rd(timer_channel_pkg::OFS_STATUS);
    chk(rdat[7:0], 32'h0, "flags clear");
    wr(timer_channel_pkg::OFS_CONTROL, 32'h2);
    rd(timer_channel_pkg::OFS_STATUS);
    chk(rdat[16], 32'h0, "clock off");
    wr(timer_channel_pkg::OFS_IRQ_SET, 32'h90);
    wr(timer_channel_pkg::OFS_IRQ_SET, 32'h0);
    rd(timer_channel_pkg::OFS_IRQ_MASK);
    chk(rdat, 32'h90, "mask set");
    wr(timer_channel_pkg::OFS_IRQ_CLR, 32'h80);
    wr(timer_channel_pkg::OFS_IRQ_CLR, 32'h0);
    rd(timer_channel_pkg::OFS_IRQ_MASK);
    chk(rdat, 32'h10, "mask clear");
    ext_pulse();
    chk(irq, 32'h0, "irq masked");
    trig();
    tick_n(1);
    chk(irq, 32'h1, "irq on");
    rd(timer_channel_pkg::OFS_STATUS);
    chk(irq, 32'h0, "irq off");
    wr(timer_channel_pkg::OFS_IRQ_CLR, 32'hff);
  endtask

  task automatic overflow();
    trig();
    tick_n(65541);
    rd(timer_channel_pkg::OFS_COUNT);
    chk(rdat, 32'h5, "count");
    rd(timer_channel_pkg::OFS_STATUS);
    chk(rdat[0], 32'h1, "overflow");
    rd(timer_channel_pkg::OFS_STATUS);
    chk(rdat[0], 32'h0, "overflow clear");
  endtask

  // capture mode: a on rise, b on fall, overrun on second unread a load
  task automatic capture();
    wr(timer_channel_pkg::OFS_MODE, 32'h0);
    pb <= 1'b1;
    trig();
    tick_n(3);
    rd(timer_channel_pkg::OFS_STATUS);
    for (int i = 0; i < 5; i++) begin
      pa <= ~pa;
      repeat (3) @(posedge core_clk_i);
      if (i == 1) begin
        rd(timer_channel_pkg::OFS_STATUS);
        chk(rdat[18:0], 32'h50060, "loads");
      end
    end
    rd(timer_channel_pkg::OFS_STATUS);
    chk(rdat[18:0], 32'h70062, "overrun");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_i = 1'b1;
    {hsel, hwrite, tick, ext, pa, pb, ea, eb} = 8'h0;
    haddr = 8'h0;
    htrans = 2'h0;
    hwdata = 32'h0;
    err_total = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    chk({irq, la, lb, la_oe, lb_oe, hresp}, 32'h0, "after reset");
    regs();
    effects(timer_channel_pkg::FLD_C_MATCH_A, timer_channel_pkg::FLD_C_MATCH_B, 2);
    effects(timer_channel_pkg::FLD_EXT_A, timer_channel_pkg::FLD_EXT_B, 1);
    effects(timer_channel_pkg::FLD_SW_A, timer_channel_pkg::FLD_SW_B, 0);
    // limit moved off zero so the a/b matches are not outranked by it
    wr(timer_channel_pkg::OFS_CMP_C, 32'h5);
    effects(timer_channel_pkg::FLD_A_MATCH_A, timer_channel_pkg::FLD_B_MATCH_B, 2);
    flags();
    overflow();
    capture();
    results();
  end
endmodule // test_timer_channel_outputs_status
